// [rtl/plc_pkg.sv]
// Constants and types shared by the synthesizer output and lock control block
// Functional notes
// RL1: Duty cycle from separate high, low counts
// RL2: Duty step is 50% over division value
// RL3: Top duty step unavailable; keep one low
// RL4: Host programs feedback counter to even split
// RL5: 20-bit gate counter holds gated lock low
// RL6: Provide both raw and gated lock outputs
// RL7: Enable restarts gate counter with loop acquisition
// RL8: Enable low drives outputs low, drops lock
// RL9: Enable high relocks and resynchronizes outputs
// RL10: Detector gate off freezes oscillator, outputs run
// RL11: Host drives detector gate from any source
// RL12: Reset input clears counters, outputs and lock
// RL13: After reset release, resynchronize while relocking
// RL14: Output enables sampled on counter falling edge
// RL15: Output enables hold every output off
// RL16: Cascading feeds one counter into next
// RL17: Cascaded chain divides by product of settings
// RL18: Cascading fixed at build, enhanced only
// RL19: Select two references, automatic or requested
// RL20: Enhanced has auto and manual; fast manual
// RL21: Enhanced divide 512 even, 256 uneven
// RL22: Fast divide 32 even, 16 uneven
// RL23: Reset also restarts the gate counter
package plc_pkg;

  // Register byte offsets
  localparam logic [4:0] ADDR_CTRL    = 5'h00;
  localparam logic [4:0] ADDR_DIV0    = 5'h04;
  localparam logic [4:0] ADDR_DIV1    = 5'h08;
  localparam logic [4:0] ADDR_LOCKCNT = 5'h0c;
  localparam logic [4:0] ADDR_STATUS  = 5'h10;

  // Control register fields
  localparam int CTRL_CLKENA_LSB = 0;
  localparam int CTRL_PFDENA     = 2;
  localparam int CTRL_SWITCH     = 3;
  localparam int CTRL_AUTO       = 4;

  // Divider register fields: division value and high time in half VCO cycles
  localparam int DIV_N_LSB  = 0;
  localparam int DIV_HI_LSB = 16;
  localparam int DIV_W      = 10;

  // Status register fields
  localparam int ST_RAWLOCK = 0;
  localparam int ST_GATED   = 1;
  localparam int ST_ACTIVE  = 2;
  localparam int ST_BAD0    = 3;
  localparam int ST_BAD1    = 4;
  localparam int ST_CASCADE = 5;
  localparam int ST_ENH     = 6;
  localparam int ST_VCOHOLD = 7;

  // Number of post-scale outputs and gate counter width
  localparam int NUM_OUT  = 2;
  localparam int GATE_W   = 20;

  // Division limits per synthesizer type
  localparam int ENH_MAX_EVEN  = 512;
  localparam int ENH_MAX_ODD   = 256;
  localparam int FAST_MAX_EVEN = 32;
  localparam int FAST_MAX_ODD  = 16;

  // Values after reset
  localparam logic [1:0]        RST_CLKENA  = 2'h3;
  localparam logic              RST_PFDENA  = 1'b1;
  localparam logic              RST_AUTO    = 1'b1;
  localparam logic [DIV_W-1:0]  RST_DIV_N   = 10'h001;
  localparam logic [DIV_W-1:0]  RST_DIV_HI  = 10'h001;
  localparam logic [GATE_W-1:0] RST_LOCKCNT = 20'h00100;

  // Post-scale divider setting
  typedef struct packed {
    logic [DIV_W-1:0] hi;
    logic [DIV_W-1:0] n;
  } plc_div_t;

  // Run state of the output counters
  typedef enum logic [1:0] {
    PLC_OFF  = 2'b00,
    PLC_WAIT = 2'b01,
    PLC_RUN  = 2'b10
  } plc_state_t;

endpackage

// [rtl/plc_top.sv]
// Output divider, lock gating, enable and reference select control
`timescale 1ns/1ps
`default_nettype none
module plc_top #(
  parameter bit ENHANCED    = 1'b1,
  parameter bit CASCADE     = 1'b0,
  parameter int ACQ_EDGES   = 8,
  parameter int LOSS_CYCLES = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pll_enable,
  input  wire logic        areset,
  input  wire logic        ref_clk0,
  input  wire logic        ref_clk1,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  clk_out,
  output logic             locked,
  output logic             gated_locked,
  output logic             active_ref
);

  localparam int LW = $clog2(LOSS_CYCLES + 1);
  localparam int AW = $clog2(ACQ_EDGES + 1);
  localparam int MAX_EVEN = ENHANCED ? plc_pkg::ENH_MAX_EVEN : plc_pkg::FAST_MAX_EVEN;
  localparam int MAX_ODD  = ENHANCED ? plc_pkg::ENH_MAX_ODD : plc_pkg::FAST_MAX_ODD;
  localparam int NO = plc_pkg::NUM_OUT;
  // Local width copy keeps the declarations below short
  localparam int DIV_W = plc_pkg::DIV_W;

  // Refuse settings the logic cannot serve
  if (CASCADE && !ENHANCED) $error("Cascading needs the enhanced type"); // RL18
  if (ACQ_EDGES < 1 || LOSS_CYCLES < 2) $error("Acquisition or loss count too small");

  // All state of the block except the assertion helper in one struct
  typedef struct packed {
    plc_pkg::plc_state_t          st;
    logic                         wait_st;
    logic [31:0]                  rdata;
    logic [1:0]                   clkena;
    logic                         pfd_en;
    logic                         sw_req;
    logic                         auto_en;
    plc_pkg::plc_div_t [NO-1:0]   div;
    logic [plc_pkg::GATE_W-1:0]   lock_cfg;
    logic [1:0]                   ref_prev;
    logic [1:0][LW-1:0]           loss;
    logic [1:0]                   bad;
    logic                         sel;
    logic                         sw_prev;
    logic                         sw_pend;
    logic [AW-1:0]                acq;
    logic                         raw_lock;
    logic [plc_pkg::GATE_W-1:0]   gcnt;
    logic                         gated;
    logic [NO-1:0][DIV_W:0]       cnt;
    logic [NO-1:0]                raw;
    logic [NO-1:0]                en_q;
    logic [NO-1:0]                out;
  } plc_regs_t;

  // Present and next state
  plc_regs_t r_reg;
  plc_regs_t r_next;

  // Legal shape of one divider: period and high time, both in half VCO cycles
  // Clamped here, not at the write, so readback shows what software wrote
  function automatic logic [2*DIV_W+1:0] plc_shape(input plc_pkg::plc_div_t d);
    logic [DIV_W-1:0] n;
    logic [DIV_W:0]   per;
    logic [DIV_W:0]   h;
    n = d.n;
    if (n == '0)
      n = 10'h001;
    if (n > DIV_W'(MAX_EVEN))
      n = DIV_W'(MAX_EVEN); // RL21 RL22
    per = {n, 1'b0}; // RL2
    h = {1'b0, d.hi};
    if (h != {1'b0, n} && n > DIV_W'(MAX_ODD))
      h = {1'b0, n}; // RL21 RL22
    if (n == 10'h001)
      h = 11'h001;
    else if (h == '0)
      h = 11'h001;
    else if (h > per - 11'h002)
      h = per - 11'h002; // RL3
    return {per, h};
  endfunction

  logic [NO-1:0][DIV_W:0] shp_per;
  logic [NO-1:0][DIV_W:0] shp_hi;

  // Per-output effective shape
  for (genvar g = 0; g < NO; g++)
  begin : g_shape
    assign {shp_per[g], shp_hi[g]} = plc_shape(r_reg.div[g]);
  end

  // Reference edge detection, hold condition and bus request
  logic [1:0] cur_ref;
  logic [1:0] tog;
  logic       act_tog;
  logic       act_rise;
  logic       hold;
  logic       bus_req;
  assign cur_ref  = {ref_clk1, ref_clk0};
  assign tog      = cur_ref ^ r_reg.ref_prev;
  assign act_tog  = tog[r_reg.sel];
  assign act_rise = act_tog & cur_ref[r_reg.sel];
  assign hold     = !pll_enable || areset;
  assign bus_req  = avs_read || avs_write;

  // Next-state logic for the whole block
  always_comb
  begin
    logic tick;
    logic [DIV_W:0] c;
    tick = 1'b0;
    c = '0;
    r_next = r_reg;

    // Bus slave: one wait cycle, then the answer
    // Read data is captured in the wait cycle so it stands at the acknowledge edge
    r_next.wait_st = !(bus_req && r_reg.wait_st);
    if (avs_read && r_reg.wait_st)
    begin
      case (avs_address)
        plc_pkg::ADDR_CTRL:
          r_next.rdata = {27'h0, r_reg.auto_en, r_reg.sw_req, r_reg.pfd_en, r_reg.clkena};
        plc_pkg::ADDR_DIV0:
          r_next.rdata = {6'h0, r_reg.div[0].hi, 6'h0, r_reg.div[0].n};
        plc_pkg::ADDR_DIV1:
          r_next.rdata = {6'h0, r_reg.div[1].hi, 6'h0, r_reg.div[1].n};
        plc_pkg::ADDR_LOCKCNT:
          r_next.rdata = {12'h0, r_reg.lock_cfg};
        plc_pkg::ADDR_STATUS:
          r_next.rdata = {24'h0, (r_reg.st != plc_pkg::PLC_OFF) && !r_reg.pfd_en,
                          ENHANCED, CASCADE, r_reg.bad, r_reg.sel, r_reg.gated,
                          r_reg.raw_lock}; // RL6
        default:
          r_next.rdata = 32'h0;
      endcase
    end
    // Writes land at the acknowledge edge; unmapped offsets change nothing
    if (avs_write && !r_reg.wait_st)
    begin
      case (avs_address)
        plc_pkg::ADDR_CTRL:
        begin
          r_next.clkena  = avs_writedata[plc_pkg::CTRL_CLKENA_LSB +: 2];
          r_next.pfd_en  = avs_writedata[plc_pkg::CTRL_PFDENA]; // RL11
          r_next.sw_req  = avs_writedata[plc_pkg::CTRL_SWITCH];
          r_next.auto_en = avs_writedata[plc_pkg::CTRL_AUTO];
        end
        plc_pkg::ADDR_DIV0:
        begin
          r_next.div[0].n  = avs_writedata[plc_pkg::DIV_N_LSB +: DIV_W];
          r_next.div[0].hi = avs_writedata[plc_pkg::DIV_HI_LSB +: DIV_W];
        end
        plc_pkg::ADDR_DIV1:
        begin
          r_next.div[1].n  = avs_writedata[plc_pkg::DIV_N_LSB +: DIV_W];
          r_next.div[1].hi = avs_writedata[plc_pkg::DIV_HI_LSB +: DIV_W];
        end
        plc_pkg::ADDR_LOCKCNT:
          r_next.lock_cfg = avs_writedata[plc_pkg::GATE_W-1:0];
        default:
          r_next.rdata = r_reg.rdata;
      endcase
    end

    // Reference activity: a reference is bad once it stops toggling
    // A reference slower than LOSS_CYCLES per transition is flagged bad; size it above
    r_next.ref_prev = cur_ref;
    for (int j = 0; j < 2; j++)
    begin
      if (tog[j])
        r_next.loss[j] = '0;
      else if (r_reg.loss[j] != LW'(LOSS_CYCLES))
        r_next.loss[j] = r_reg.loss[j] + LW'(1);
      r_next.bad[j] = (r_next.loss[j] == LW'(LOSS_CYCLES));
    end

    // Reference select; in the enhanced type a request waits until the other input is alive
    // Enhanced type edge-detects the request bit, so holding it high does not bounce the select; the fast type follows the bit
    r_next.sw_prev = r_reg.sw_req;
    if (ENHANCED)
    begin
      if (r_reg.sw_req && !r_reg.sw_prev)
        r_next.sw_pend = 1'b1; // RL19
      if (r_next.sw_pend && !r_reg.bad[!r_reg.sel])
      begin
        r_next.sel = !r_reg.sel;
        r_next.sw_pend = 1'b0;
      end
      else if (r_reg.auto_en && r_reg.bad[r_reg.sel] && !r_reg.bad[!r_reg.sel])
        r_next.sel = !r_reg.sel; // RL19 RL20
    end
    else
      r_next.sel = r_reg.sw_req; // RL20

    // Run state: outputs restart only on an active reference rising edge
    // Waiting for that edge lines the first output edge up with the input
    case (r_reg.st)
      plc_pkg::PLC_OFF:
        r_next.st = plc_pkg::PLC_WAIT;
      plc_pkg::PLC_WAIT:
        if (act_rise)
          r_next.st = plc_pkg::PLC_RUN; // RL9 RL13
      plc_pkg::PLC_RUN:
        r_next.st = plc_pkg::PLC_RUN;
      default:
        r_next.st = plc_pkg::PLC_OFF;
    endcase

    // Raw lock; with the detector gated off the loop state is frozen
    // Acquisition is modelled by counting active rising edges, not by phase error
    if (r_reg.pfd_en)
    begin
      if (r_reg.bad[r_reg.sel])
      begin
        r_next.acq = '0;
        r_next.raw_lock = 1'b0;
      end
      else if (act_rise && r_reg.acq != AW'(ACQ_EDGES))
        r_next.acq = r_reg.acq + AW'(1);
      if (!r_reg.bad[r_reg.sel])
        r_next.raw_lock = (r_next.acq == AW'(ACQ_EDGES)); // RL6
    end // RL10

    // Gated lock counts reference transitions up to the programmed value
    // Both edges count, and it never falls until the next hold
    if (!r_reg.gated && act_tog)
    begin
      r_next.gcnt = r_reg.gcnt + 20'h00001;
      if (r_next.gcnt >= r_reg.lock_cfg)
        r_next.gated = 1'b1; // RL5
    end

    // Post-scale counters, ticking twice per VCO cycle
    // The level follows the count before the tick, so the first pulse is whole
    // A cascaded counter ticks on both edges of the upstream level
    for (int i = 0; i < NO; i++)
    begin
      if (i == 0 || !CASCADE)
        tick = (r_reg.st == plc_pkg::PLC_RUN);
      else
        tick = (r_next.raw[i-1] != r_reg.raw[i-1]); // RL16 RL17
      if (tick)
      begin
        c = (r_reg.cnt[i] >= shp_per[i] - 11'h001) ? '0 : r_reg.cnt[i] + 11'h001;
        r_next.cnt[i] = c;
        r_next.raw[i] = (r_reg.cnt[i] < shp_hi[i]); // RL1
      end
      if (r_reg.raw[i] && !r_next.raw[i])
        r_next.en_q[i] = r_reg.clkena[i]; // RL14
      r_next.out[i] = r_next.raw[i] && r_next.en_q[i]; // RL15
    end

    // Disable or reset clears counters, outputs and both locks together
    // Settings and the reference monitors survive, so software need not reprogram
    if (hold)
    begin
      r_next.st       = plc_pkg::PLC_OFF; // RL8 RL12
      r_next.acq      = '0;
      r_next.raw_lock = 1'b0;
      r_next.gcnt     = '0; // RL7 RL23
      r_next.gated    = 1'b0;
      r_next.cnt      = '0;
      r_next.raw      = '0;
      r_next.en_q     = '0;
      r_next.out      = '0;
    end
  end

  // State register with synchronous reset
  // Whole-struct clear first, then the non-zero values after reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r_reg          <= '0;
      r_reg.st       <= plc_pkg::PLC_OFF;
      r_reg.wait_st  <= 1'b1;
      r_reg.clkena   <= plc_pkg::RST_CLKENA;
      r_reg.pfd_en   <= plc_pkg::RST_PFDENA;
      r_reg.auto_en  <= plc_pkg::RST_AUTO;
      r_reg.div      <= {NO{plc_pkg::RST_DIV_HI, plc_pkg::RST_DIV_N}};
      r_reg.lock_cfg <= plc_pkg::RST_LOCKCNT;
    end
    else
      r_reg <= r_next;
  end

  // Every output straight from a flip-flop
  assign avs_readdata    = r_reg.rdata;
  assign avs_waitrequest = r_reg.wait_st;
  assign clk_out         = r_reg.out;
  assign locked          = r_reg.raw_lock;
  assign gated_locked    = r_reg.gated;
  assign active_ref      = r_reg.sel;

  // Helper: length of the current high phase of output 0
  // Kept outside the state struct because only the assertions read it
  logic [DIV_W:0] hi_run;
  always_ff @(posedge clk)
  begin
    if (!rst_n || !r_reg.raw[0])
      hi_run <= '0;
    else
      hi_run <= hi_run + 11'h001;
  end

  // Checks run on the system clock and are masked during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_high_len: assert property ( // RL1
    (r_reg.st == plc_pkg::PLC_RUN && $fell(r_reg.raw[0]) && !hold
     && $stable(r_reg.div[0])) |-> (hi_run == shp_hi[0]))
    else $error("High phase length differs from setting");
  chk_low_step: assert property ( // RL3
    (r_reg.st == plc_pkg::PLC_RUN && $stable(r_reg.div[0])) |-> (hi_run < shp_per[0] - 11'h001))
    else $error("High time leaves no low step");
  chk_gate_hold: assert property ( // RL5
    $rose(r_reg.gated) |-> (r_reg.gcnt >= r_reg.lock_cfg && $past(act_tog)))
    else $error("Gated lock rose before its count");
  chk_enable_off: assert property ( // RL8
    !pll_enable |=> (clk_out == 2'h0 && !locked && !gated_locked))
    else $error("Outputs or lock active while disabled");
  chk_areset_clear: assert property ( // RL12
    areset |=> (r_reg.gcnt == '0 && r_reg.cnt == '0 && r_reg.st == plc_pkg::PLC_OFF))
    else $error("Reset input did not clear counters");
  chk_resync_wait: assert property ( // RL13
    (r_reg.st == plc_pkg::PLC_WAIT && !act_rise && !hold) |=> (r_reg.st == plc_pkg::PLC_WAIT))
    else $error("Outputs started without a reference edge");
  chk_glitch_free: assert property ( // RL14
    $rose(clk_out[0]) |-> $rose(r_reg.raw[0]))
    else $error("Output enabled in mid pulse");
  chk_pfd_hold: assert property ( // RL10
    (!r_reg.pfd_en && !hold && r_reg.st != plc_pkg::PLC_OFF) |=> $stable(locked))
    else $error("Lock moved while detector gated off");
  chk_fast_manual: assert property ( // RL20
    (!ENHANCED && !$past(r_reg.sel ^ r_reg.sw_req)) |=> (active_ref == $past(r_reg.sw_req)))
    else $error("Fast type select does not follow request");

  // Checks on restart, lock loss, cascading and enable latching
  chk_gate_restart: assert property ( // RL7
    $rose(pll_enable) |-> (r_reg.gcnt == '0 && !gated_locked))
    else $error("Gate count did not restart with enable");
  chk_raw_drop: assert property ( // RL6
    (r_reg.pfd_en && r_reg.bad[r_reg.sel]) |=> !locked)
    else $error("Raw lock held on a dead reference");
  chk_cascade_tick: assert property ( // RL16
    (CASCADE && !$past(hold) && $stable(r_reg.raw[0])) |-> $stable(r_reg.cnt[1]))
    else $error("Cascaded counter moved without an upstream edge");
  chk_en_latch: assert property ( // RL14
    (r_reg.en_q[0] != $past(r_reg.en_q[0]) && !$past(hold)) |-> $fell(r_reg.raw[0]))
    else $error("Output enable changed away from a falling edge");

  // Main scenarios the bench should reach

  cov_gated_lock: cover property ($rose(gated_locked));
  cov_switch_ref: cover property ($changed(active_ref));
  cov_out_run:    cover property ($rose(clk_out[0]) ##[1:100] $rose(clk_out[0]));
  cov_bus_write:  cover property (avs_write && !avs_waitrequest);
  cov_out_off:    cover property ($fell(r_reg.en_q[0]));

endmodule
`default_nettype wire

// [testbench/plc_ref_model.sv]
// Reference clock pair that the core side feeds into the control block
`timescale 1ns/1ps
`default_nettype none
module plc_ref_model #(
  parameter int HALF = 2
) (
  input  wire logic clk,
  input  wire logic stop0,
  input  wire logic stop1,
  output logic      ref_clk0,
  output logic      ref_clk1
);
  int   cnt = 0;
  logic r0  = 1'b0;
  logic r1  = 1'b0;

  // Both references toggle every HALF cycles; a stopped one sticks low like a dead source
  always @(posedge clk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
    begin
      r0 <= stop0 ? 1'b0 : ~r0;
      r1 <= stop1 ? 1'b0 : ~r1;
    end
  end

  // One driver per reference pin
  assign ref_clk0 = r0;
  assign ref_clk1 = r1;
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the output divider and lock control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [4:0]  a;
    logic [31:0] v;
  } plc_row_t;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        pll_enable = 1'b0;
  logic        areset = 1'b0;
  logic        stop0 = 1'b0;
  logic        ref_clk0, ref_clk1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  clk_out;
  logic        locked, gated_locked, active_ref, fast_ref;
  int          err_count = 0;
  int          comparisons = 0;
  logic [31:0] q;
  int          c;
  // Reset values, the unmapped hole and the read-only status word
  plc_row_t    rows [6] = '{'{plc_pkg::ADDR_CTRL, 32'h17}, '{plc_pkg::ADDR_DIV0, 32'h10001},
    '{plc_pkg::ADDR_DIV1, 32'h10001}, '{plc_pkg::ADDR_LOCKCNT, 32'h100},
    '{plc_pkg::ADDR_STATUS, 32'h60}, '{5'h14, 32'h0}};

  // Small acquire and loss counts keep the run short; out1 cascades from out0
  plc_top #(.CASCADE(1'b1), .ACQ_EDGES(2), .LOSS_CYCLES(4)) uut (.clk(clk), .rst_n(rst_n),
    .pll_enable(pll_enable), .areset(areset), .ref_clk0(ref_clk0), .ref_clk1(ref_clk1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .clk_out(clk_out), .locked(locked),
    .gated_locked(gated_locked), .active_ref(active_ref));

  // Fast type on the same bus and references: manual select only
  plc_top #(.ENHANCED(1'b0), .ACQ_EDGES(2), .LOSS_CYCLES(4)) uut_fast (.clk(clk),
    .rst_n(rst_n), .pll_enable(pll_enable), .areset(areset), .ref_clk0(ref_clk0),
    .ref_clk1(ref_clk1), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(),
    .avs_waitrequest(), .clk_out(), .locked(), .gated_locked(), .active_ref(fast_ref));

  plc_ref_model #(.HALF(2)) refs (.clk(clk), .stop0(stop0), .stop1(1'b0),
    .ref_clk0(ref_clk0), .ref_clk1(ref_clk1));

  always #5 clk = ~clk;

  task complete_run;
    $display("errors %0d of %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One Avalon transfer; the request stands until waitrequest is sampled low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      chk("bus_timeout", 32'h1, 32'h0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  function automatic logic pick(input int s);
    logic [4:0] v;
    v = {active_ref, gated_locked, locked, clk_out};
    return v[s];
  endfunction

  // Counts cycles while the selected output holds level v, bounded
  task run(input int s, input logic v, output int n);
    n = 0;
    while (pick(s) === v && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  // Skips to a rising boundary, then times one high and one low phase
  task meas(input int i, input int hi, input int lo);
    int h, l;
    run(i, 1'b1, h);
    run(i, 1'b0, l);
    run(i, 1'b1, h);
    run(i, 1'b0, l);
    chk("high_time", 32'(h), 32'(hi));
    chk("low_time", 32'(l), 32'(lo));
  endtask

  // Gated lock must wait out twelve reference transitions, raw lock comes first
  task relock;
    run(3, 1'b0, c);
    chk("gate_delay", 32'(c >= 20 && c <= 34), 32'h1);
    chk("raw_lock", 32'(locked), 32'h1);
  endtask

  initial
  begin
    #100000;
    err_count++;
    complete_run;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    chk("reset_out", 32'({avs_waitrequest, clk_out, locked, gated_locked}), 32'h10);
    chk("reset_ref", 32'({active_ref, fast_ref}), 32'h0);
    chk("reset_rdata", avs_readdata, 32'h0);
    foreach (rows[k])
    begin
      bus(1'b0, rows[k].a, 32'h0, q);
      chk("reg_read", q, rows[k].v);
    end
    bus(1'b1, plc_pkg::ADDR_STATUS, 32'hff, q);
    bus(1'b0, plc_pkg::ADDR_STATUS, 32'h0, q);
    chk("status_ro", q, 32'h60);
    // Out0 even split as a feedback counter would need; out1 asks for too much high time
    bus(1'b1, plc_pkg::ADDR_DIV0, 32'h20002, q);
    bus(1'b1, plc_pkg::ADDR_DIV1, 32'h90003, q);
    bus(1'b1, plc_pkg::ADDR_LOCKCNT, 32'hc, q);
    pll_enable <= 1'b1;
    relock;
    meas(0, 2, 2);
    meas(1, 8, 4);
    // Output enable off on out0 only
    bus(1'b1, plc_pkg::ADDR_CTRL, 32'h16, q);
    repeat (8) @(posedge clk);
    c = 0;
    repeat (20)
    begin
      @(posedge clk);
      c += int'(clk_out[0]);
    end
    chk("out0_gated", 32'(c), 32'h0);
    meas(1, 8, 4);
    bus(1'b1, plc_pkg::ADDR_CTRL, 32'h17, q);
    meas(0, 2, 2);
    // Detector gate off: oscillator holds, outputs and lock keep going
    bus(1'b1, plc_pkg::ADDR_CTRL, 32'h13, q);
    bus(1'b0, plc_pkg::ADDR_STATUS, 32'h0, q);
    chk("vco_hold", 32'(q[7]), 32'h1);
    meas(0, 2, 2);
    chk("lock_frozen", 32'(locked), 32'h1);
    bus(1'b1, plc_pkg::ADDR_CTRL, 32'h17, q);
    // Global enable low clears outputs and both locks, high again relocks
    pll_enable <= 1'b0;
    repeat (3) @(posedge clk);
    chk("enable_off", 32'({clk_out, locked, gated_locked}), 32'h0);
    pll_enable <= 1'b1;
    relock;
    meas(0, 2, 2);
    // Loop reset acts the same and restarts the gate count
    areset <= 1'b1;
    repeat (3) @(posedge clk);
    chk("areset_hold", 32'({clk_out, locked, gated_locked}), 32'h0);
    areset <= 1'b0;
    relock;
    meas(1, 8, 4);
    // Dead primary: automatic switch to the secondary
    stop0 <= 1'b1;
    run(4, 1'b0, c);
    chk("auto_switch", 32'(c <= 40), 32'h1);
    chk("fast_no_auto", 32'(fast_ref), 32'h0);
    bus(1'b0, plc_pkg::ADDR_STATUS, 32'h0, q);
    chk("ref0_bad", 32'(q[3]), 32'h1);
    stop0 <= 1'b0;
    repeat (20) @(posedge clk);
    // Switch request edge sends it back to the primary
    bus(1'b1, plc_pkg::ADDR_CTRL, 32'h1f, q);
    run(4, 1'b1, c);
    chk("manual_switch", 32'(c <= 40), 32'h1);
    chk("fast_manual", 32'(fast_ref), 32'h1);
    complete_run;
  end
endmodule
`default_nettype wire
